// ==== rtl/pef_event_flags.sv ====
// pef_event_flags: protocol and startup event flags with interrupt request
// assumes engine strobes are one-cycle pulses on core_clk, host port same clock
// What this block does
// R1: set cycle start flag at cycle begin
// R2: set timer flag on cycle and offset match
// R3: reset timer setup zero, both timer flags show
// R4: all enables reset to zero, no request
// R5: request held while enabled flag stays set
// R6: missing offset flag at every cycle end
// R7: guardian error on either channel sets flag
// R8: masked slot counter increment sets flag
// R9: missing rate flag at odd cycle end
// R10: error level change sets its flag
// R11: too many sync frames sets overflow flag
// R12: correction reaching its limit sets flag
// R13: illegal state sets fatal, forces diagnosis stop
// R14: startup status resets zero, cleared leaving config
// R15: startup flags clear on one, keep on zero
// R16: device set beats simultaneous host clear
// R17: Nth failed coldstart retry sets retry flag
// R18: too few startup frames sets plausibility flag
// R19: noise path coldstart entry sets bit three
// R20: normal path coldstart entry sets bit two
// R21: per-flag startup enables, upper bits read zero
// R22: main status bit layout fifteen down five
// R23: main flags clear on one, set wins
// R24: main status cleared by reset, leaving config
// R25: request is OR of flag AND enable
`timescale 1ns/100ps
module pef_event_flags
    import pef_pkg::*;
#(
    parameter int CYC_W = 6,
    parameter int MT_W = 14
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // host register port
    input wire logic host_sel,
    input wire logic host_wr,
    input wire logic [9:0] host_addr,
    input wire logic [15:0] host_wdata,
    output logic [15:0] host_rdata,
    // engine timing
    input wire logic in_config,
    input wire logic cycle_start,
    input wire logic cycle_end,
    input wire logic cycle_odd,
    input wire logic [CYC_W-1:0] cycle_count,
    input wire logic [MT_W-1:0] macrotick,
    // clock sync results
    input wire logic offset_meas_short,
    input wire logic rate_pair_short,
    input wire logic sync_frame_seen,
    input wire logic corr_valid,
    input wire logic [15:0] offset_corr_mag,
    input wire logic [15:0] rate_corr_mag,
    // error sources
    input wire logic guardian_err_a,
    input wire logic guardian_err_b,
    input wire logic [7:0] slot_counter_inc,
    input wire logic [1:0] error_level,
    input wire logic illegal_state,
    // startup events
    input wire logic coldstart_retry_fail,
    input wire logic startup_frames_short,
    input wire logic coldstart_normal_entry,
    input wire logic coldstart_noise_entry,
    // results
    output logic sync_capture_en,
    output logic diag_stop,
    output logic irq
);
    // ==========================================================
    // state
    typedef struct packed {
        logic [MAIN_W-1:0] main_en;
        logic [SU_W-1:0] su_en;
        logic [1:0][15:0] t_cyc;
        logic [1:0][15:0] t_mt;
        logic [7:0] retry_lim;
        logic [7:0] retry_cnt;
        logic [7:0] sync_lim;
        logic [7:0] sync_cnt;
        logic [15:0] offset_lim;
        logic [15:0] rate_lim;
        logic [7:0] slot_mask;
        logic [1:0] prev_level;
        logic prev_config;
        logic diag_stop;
        logic [15:0] rdata;
    } pef_state_type;

    pef_state_type st_ff;
    pef_state_type nxt_st;

    pef_flag_if #(.W(MAIN_W)) main_if ();
    pef_flag_if #(.W(SU_W)) su_if ();

    logic [1:0] timer_hit;
    logic config_exit;
    logic wr_main;
    logic wr_su;
    logic [15:0] main_word;
    logic [15:0] su_word;

    // ==========================================================
    // flag banks and timers
    pef_flag_bank #(.W(MAIN_W)) u_main_bank (
        .core_clk(core_clk),
        .nrst(nrst),
        .fl(main_if)
    );

    pef_flag_bank #(.W(SU_W)) u_su_bank (
        .core_clk(core_clk),
        .nrst(nrst),
        .fl(su_if)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_timer
            pef_timer_match #(.CYC_W(CYC_W), .MT_W(MT_W)) u_match (
                .cyc_cfg(st_ff.t_cyc[gi]),
                .mt_cfg(st_ff.t_mt[gi]),
                .cycle_count(cycle_count),
                .macrotick(macrotick),
                .match(timer_hit[gi])
            );
        end
    endgenerate

    // ==========================================================
    // event sources
    assign config_exit = st_ff.prev_config && !in_config;
    assign wr_main = host_sel && host_wr && (host_addr == OFS_MAIN_STATUS);
    assign wr_su = host_sel && host_wr && (host_addr == OFS_STARTUP_STATUS);

    always_comb begin
        main_if.set = '0;
        main_if.set[IX_CYCLE] = cycle_start; // see R1
        main_if.set[IX_TIMER0 +: 2] = timer_hit; // see R2 see R3
        main_if.set[IX_OFFSET] = cycle_end && offset_meas_short; // see R6
        main_if.set[IX_GUARD] = guardian_err_a || guardian_err_b; // see R7
        main_if.set[IX_SLOT] = |(slot_counter_inc & st_ff.slot_mask); // see R8
        main_if.set[IX_RATE] = cycle_end && cycle_odd && rate_pair_short; // see R9
        main_if.set[IX_LEVEL] = error_level != st_ff.prev_level; // see R10
        main_if.set[IX_SYNC] = sync_frame_seen && (st_ff.sync_cnt >= st_ff.sync_lim); // see R11
        main_if.set[IX_LIMIT] = corr_valid && ((offset_corr_mag >= st_ff.offset_lim)
            || (rate_corr_mag >= st_ff.rate_lim)); // see R12
        main_if.set[IX_FATAL] = illegal_state; // see R13
    end

    always_comb begin
        su_if.set = '0;
        su_if.set[SU_RETRY] = coldstart_retry_fail && (st_ff.retry_lim != 8'h00)
            && (st_ff.retry_cnt + 8'h01 == st_ff.retry_lim); // see R17
        su_if.set[SU_PLAUS] = startup_frames_short; // see R18
        su_if.set[SU_NORMAL] = coldstart_normal_entry; // see R20
        su_if.set[SU_NOISE] = coldstart_noise_entry; // see R19
    end

    // write-one-clear, zero bits keep; the banks let sets win
    assign main_if.w1c = wr_main ? host_wdata[MAIN_LSB +: MAIN_W] : '0; // see R23
    assign su_if.w1c = wr_su ? host_wdata[SU_W-1:0] : '0; // see R15 see R16
    assign main_if.clr_all = config_exit; // see R24
    assign su_if.clr_all = config_exit; // see R14

    // status words; unused low main bits and upper startup bits read zero
    assign main_word = {main_if.flags, {MAIN_LSB{1'b0}}}; // see R22
    assign su_word = {{(16-SU_W){1'b0}}, su_if.flags}; // see R21

    // ==========================================================
    // registers, counters, read data
    always_comb begin
        nxt_st = st_ff;
        nxt_st.prev_level = error_level;
        nxt_st.prev_config = in_config;
        if (cycle_start) begin
            nxt_st.sync_cnt = 8'h00;
        end else if (sync_frame_seen && st_ff.sync_cnt != 8'hff) begin
            nxt_st.sync_cnt = st_ff.sync_cnt + 8'h01;
        end
        if (config_exit) begin
            nxt_st.retry_cnt = 8'h00;
        end else if (coldstart_retry_fail && st_ff.retry_cnt != 8'hff) begin
            nxt_st.retry_cnt = st_ff.retry_cnt + 8'h01;
        end
        if (illegal_state) begin
            nxt_st.diag_stop = 1'b1; // see R13
        end else if (in_config) begin
            nxt_st.diag_stop = 1'b0;
        end
        if (host_sel && host_wr) begin
            unique case (host_addr)
                OFS_MAIN_EN: nxt_st.main_en = host_wdata[MAIN_LSB +: MAIN_W];
                OFS_STARTUP_EN: nxt_st.su_en = host_wdata[SU_W-1:0]; // see R21
                OFS_TIMER0_CYC: nxt_st.t_cyc[0] = host_wdata;
                OFS_TIMER0_MT: nxt_st.t_mt[0] = host_wdata;
                OFS_TIMER1_CYC: nxt_st.t_cyc[1] = host_wdata;
                OFS_TIMER1_MT: nxt_st.t_mt[1] = host_wdata;
                OFS_RETRY_LIMIT: nxt_st.retry_lim = host_wdata[7:0];
                OFS_SYNC_LIMIT: nxt_st.sync_lim = host_wdata[7:0];
                OFS_OFFSET_LIMIT: nxt_st.offset_lim = host_wdata;
                OFS_RATE_LIMIT: nxt_st.rate_lim = host_wdata;
                OFS_SLOT_MASK: nxt_st.slot_mask = host_wdata[7:0];
                default: begin
                end
            endcase
        end
        if (host_sel && !host_wr) begin
            unique case (host_addr)
                OFS_MAIN_EN: nxt_st.rdata = {st_ff.main_en, {MAIN_LSB{1'b0}}};
                OFS_MAIN_STATUS: nxt_st.rdata = main_word;
                OFS_STARTUP_STATUS: nxt_st.rdata = su_word;
                OFS_STARTUP_EN: nxt_st.rdata = {{(16-SU_W){1'b0}}, st_ff.su_en};
                OFS_TIMER0_CYC: nxt_st.rdata = st_ff.t_cyc[0];
                OFS_TIMER0_MT: nxt_st.rdata = st_ff.t_mt[0];
                OFS_TIMER1_CYC: nxt_st.rdata = st_ff.t_cyc[1];
                OFS_TIMER1_MT: nxt_st.rdata = st_ff.t_mt[1];
                OFS_RETRY_LIMIT: nxt_st.rdata = {8'h00, st_ff.retry_lim};
                OFS_SYNC_LIMIT: nxt_st.rdata = {8'h00, st_ff.sync_lim};
                OFS_OFFSET_LIMIT: nxt_st.rdata = st_ff.offset_lim;
                OFS_RATE_LIMIT: nxt_st.rdata = st_ff.rate_lim;
                OFS_SLOT_MASK: nxt_st.rdata = {8'h00, st_ff.slot_mask};
                default: nxt_st.rdata = 16'h0000;
            endcase
        end
    end

    // enables and timer setup come out of reset cleared
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_ff.main_en <= '0; // see R4
            st_ff.su_en <= '0; // see R4
            st_ff.t_cyc <= {CFG_RST, CFG_RST}; // see R3
            st_ff.t_mt <= {CFG_RST, CFG_RST}; // see R3
            st_ff.retry_lim <= 8'h00;
            st_ff.retry_cnt <= 8'h00;
            st_ff.sync_lim <= 8'h00;
            st_ff.sync_cnt <= 8'h00;
            st_ff.offset_lim <= 16'hffff;
            st_ff.rate_lim <= 16'hffff;
            st_ff.slot_mask <= 8'h00;
            st_ff.prev_level <= 2'h0;
            st_ff.prev_config <= 1'b1;
            st_ff.diag_stop <= 1'b0;
            st_ff.rdata <= STATUS_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // outputs
    assign host_rdata = st_ff.rdata;
    assign diag_stop = st_ff.diag_stop;
    // measurements past the configured sync count are dropped
    assign sync_capture_en = st_ff.sync_cnt < st_ff.sync_lim; // see R11
    assign irq = |(main_if.flags & st_ff.main_en) | |(su_if.flags & st_ff.su_en); // see R25 see R5

    // ==========================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence s_illegal;
        illegal_state;
    endsequence

    sequence s_stopped;
        diag_stop && main_if.flags[IX_FATAL];
    endsequence

    a_cycle_start_set: // see R1
        assert property (cycle_start |=> main_if.flags[IX_CYCLE])
        else $error("cycle start flag not set");

    a_timer_zero_match: // see R3
        assert property ((cycle_count == '0) && (macrotick == '0)
            && (st_ff.t_cyc == '0) && (st_ff.t_mt == '0)
            |=> (main_word & 16'h00c0) == 16'h00c0)
        else $error("timer flags not shown with zero setup");

    a_no_enable_quiet: // see R4
        assert property ((st_ff.main_en == '0) && (st_ff.su_en == '0) |-> !irq)
        else $error("request raised with enables clear");

    a_irq_held_flag: // see R5
        assert property (su_if.flags[SU_NORMAL] && st_ff.su_en[SU_NORMAL]
            && $stable(su_if.flags) |-> irq)
        else $error("request dropped while flag enabled");

    a_odd_rate_set: // see R9
        assert property (cycle_end && cycle_odd && rate_pair_short
            |=> main_if.flags[IX_RATE])
        else $error("missing rate flag not set");

    a_fatal_stop_seq: // see R13
        assert property (s_illegal |=> s_stopped)
        else $error("fatal without diagnosis stop");

    a_main_w1c_clear: // see R23
        assert property (wr_main && host_wdata[MAIN_LSB] && !cycle_start
            |=> !main_if.flags[IX_CYCLE])
        else $error("main flag not cleared by one");

    a_su_zero_keeps: // see R15
        assert property (wr_su && !host_wdata[SU_NOISE] && su_if.flags[SU_NOISE]
            && !config_exit |=> su_if.flags[SU_NOISE])
        else $error("writing zero changed startup flag");

    a_set_beats_w1c: // see R16
        assert property (wr_su && host_wdata[SU_NORMAL] && coldstart_normal_entry
            |=> su_if.flags[SU_NORMAL])
        else $error("host clear beat device set");

    a_exit_clears: // see R14
        assert property (config_exit && (su_if.set == '0) |=> su_word == 16'h0000)
        else $error("startup status kept after leaving config");

    a_retry_nth_fail: // see R17
        assert property (coldstart_retry_fail && !config_exit && (st_ff.retry_lim != 8'h00)
            && (st_ff.retry_lim == st_ff.retry_cnt + 8'h01)
            |=> su_if.flags[SU_RETRY] ##1 $stable(st_ff.retry_lim))
        else $error("retry limit flag missed");

    a_guard_either_set: // see R7
        assert property ((guardian_err_a || guardian_err_b)
            |=> main_if.flags[IX_GUARD])
        else $error("guardian flag not set");

    a_slot_masked_set: // see R8
        assert property ((slot_counter_inc & st_ff.slot_mask) != 8'h00
            |=> main_if.flags[IX_SLOT])
        else $error("slot counter flag not set");

    a_level_change_set: // see R10
        assert property (error_level != $past(error_level)
            |=> main_if.flags[IX_LEVEL])
        else $error("error level change flag not set");

    a_sync_over_set: // see R11
        assert property (sync_frame_seen && !sync_capture_en
            |=> main_if.flags[IX_SYNC])
        else $error("sync overflow flag not set");
endmodule

// ==== rtl/pef_pkg.sv ====
// pef_pkg: offsets, field positions, reset values of the protocol event flags
// assumes a 16-bit host port that addresses word registers by byte offset
package pef_pkg;
    // ==========================================================
    // register offsets
    localparam logic [9:0] OFS_MAIN_EN = 10'h00c;
    localparam logic [9:0] OFS_MAIN_STATUS = 10'h00e;
    localparam logic [9:0] OFS_STARTUP_STATUS = 10'h010;
    localparam logic [9:0] OFS_STARTUP_EN = 10'h012;
    localparam logic [9:0] OFS_TIMER0_CYC = 10'h014;
    localparam logic [9:0] OFS_TIMER0_MT = 10'h016;
    localparam logic [9:0] OFS_TIMER1_CYC = 10'h018;
    localparam logic [9:0] OFS_TIMER1_MT = 10'h01a;
    localparam logic [9:0] OFS_RETRY_LIMIT = 10'h01c;
    localparam logic [9:0] OFS_SYNC_LIMIT = 10'h01e;
    localparam logic [9:0] OFS_OFFSET_LIMIT = 10'h020;
    localparam logic [9:0] OFS_RATE_LIMIT = 10'h022;
    localparam logic [9:0] OFS_SLOT_MASK = 10'h024;
    // ==========================================================
    // main status: bank index i sits at register bit MAIN_LSB + i
    localparam int MAIN_LSB = 5;
    localparam int MAIN_W = 11;
    localparam int IX_CYCLE = 0;
    localparam int IX_TIMER0 = 1;
    localparam int IX_OFFSET = 3;
    localparam int IX_GUARD = 4;
    localparam int IX_SLOT = 5;
    localparam int IX_RATE = 6;
    localparam int IX_LEVEL = 7;
    localparam int IX_SYNC = 8;
    localparam int IX_LIMIT = 9;
    localparam int IX_FATAL = 10;
    // ==========================================================
    // startup status bits
    localparam int SU_W = 4;
    localparam int SU_RETRY = 0;
    localparam int SU_PLAUS = 1;
    localparam int SU_NORMAL = 2;
    localparam int SU_NOISE = 3;
    // ==========================================================
    // timer cycle field: base in [5:0], ignored-bit mask in [13:8]
    localparam int TCYC_BASE_LSB = 0;
    localparam int TCYC_MASK_LSB = 8;
    // ==========================================================
    // reset values
    localparam logic [15:0] CFG_RST = 16'h0000;
    localparam logic [15:0] STATUS_RST = 16'h0000;
endpackage

// ==== rtl/pef_flag_if.sv ====
// pef_flag_if: set, write-one-clear and clear-all lines of one flag bank
// assumes a single clock domain shared by both ends
`timescale 1ns/100ps
interface pef_flag_if #(parameter int W = 4);
    logic [W-1:0] set;
    logic [W-1:0] w1c;
    logic clr_all;
    logic [W-1:0] flags;
    modport bank (input set, input w1c, input clr_all, output flags);
    modport ctrl (output set, output w1c, output clr_all, input flags);
endinterface

// ==== rtl/pef_flag_bank.sv ====
// pef_flag_bank: sticky event flags, cleared by writing ones or by clr_all
// assumes set, w1c and clr_all come from logic on the same clock
`timescale 1ns/100ps
module pef_flag_bank
    import pef_pkg::*;
#(
    parameter int W = 4
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // flag lines
    pef_flag_if.bank fl
);
    typedef struct packed {
        logic [W-1:0] flags;
    } pef_bank_type;

    pef_bank_type st_ff;
    pef_bank_type nxt_st;

    // a hardware set always beats any clear in the same cycle
    always_comb begin
        nxt_st = st_ff;
        if (fl.clr_all) begin
            nxt_st.flags = '0;
        end
        nxt_st.flags = (nxt_st.flags & ~fl.w1c) | fl.set;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign fl.flags = st_ff.flags;
endmodule

// ==== rtl/pef_timer_match.sv ====
// pef_timer_match: compares one timer's cycle set and offset with the clock
// assumes cycle count and macrotick come from the engine on core_clk
`timescale 1ns/100ps
module pef_timer_match
    import pef_pkg::*;
#(
    parameter int CYC_W = 6,
    parameter int MT_W = 14
) (
    // timer setup
    input wire logic [15:0] cyc_cfg,
    input wire logic [15:0] mt_cfg,
    // engine time
    input wire logic [CYC_W-1:0] cycle_count,
    input wire logic [MT_W-1:0] macrotick,
    // result
    output logic match
);
    logic [CYC_W-1:0] base;
    logic [CYC_W-1:0] ignore;

    assign base = cyc_cfg[TCYC_BASE_LSB +: CYC_W];
    assign ignore = cyc_cfg[TCYC_MASK_LSB +: CYC_W];
    // masked cycle bits give repetitions of a power of two
    assign match = ((cycle_count & ~ignore) == (base & ~ignore))
        && (macrotick == mt_cfg[MT_W-1:0]);
endmodule

// ==== dv/pef_host_model.sv ====
// pef_host_model: host processor side of the register port
// assumes the block samples the port on the rising edge of core_clk
`timescale 1ns/100ps
module pef_host_model (
    // clock
    input wire logic core_clk,
    // register port
    output logic host_sel,
    output logic host_wr,
    output logic [9:0] host_addr,
    output logic [15:0] host_wdata,
    input wire logic [15:0] host_rdata
);
    localparam time DLY = 10;
    initial begin
        host_sel = 1'b0;
        host_wr = 1'b0;
        host_addr = 10'h000;
        host_wdata = 16'h0000;
    end
    // ==========================================================
    // access tasks: request held until the taking edge, then an idle cycle
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        host_sel = 1'b1;
        host_wr = 1'b1;
        host_addr = a;
        host_wdata = d; // ones clear flags, zeros leave them
        @(posedge core_clk);
        #DLY;
        host_sel = 1'b0;
        host_wr = 1'b0;
        @(posedge core_clk);
        #DLY;
    endtask
    task automatic rd(input logic [9:0] a, output logic [15:0] d);
        host_sel = 1'b1;
        host_wr = 1'b0;
        host_addr = a;
        @(posedge core_clk);
        #DLY;
        d = host_rdata;
        host_sel = 1'b0;
        @(posedge core_clk);
        #DLY;
    endtask
endmodule

// ==== dv/pef_event_flags_tb.sv ====
// pef_event_flags_tb: register-level checks of the event flags and request
// assumes engine strobes are driven here as one-cycle pulses on core_clk
`timescale 1ns/100ps
module pef_event_flags_tb;
    import pef_pkg::*;
    localparam time DLY = 10;
    logic core_clk, nrst, host_sel, host_wr, in_config, cycle_odd;
    logic [9:0] host_addr;
    logic [15:0] host_wdata, host_rdata, off_mag, rate_mag, rd_val;
    logic [5:0] cyc_cnt;
    logic [13:0] mtick;
    logic [7:0] slot_inc;
    logic [1:0] err_lvl;
    logic [10:0] ev;
    logic off_short, rate_short, sync_cap_en, diag_stop, irq;
    int error_cnt = 0;
    int compares = 0;
    // ==========================================================
    // clock, instances
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    pef_host_model u_host (.core_clk(core_clk), .host_sel(host_sel), .host_wr(host_wr),
        .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata));
    pef_event_flags #(.CYC_W(6), .MT_W(14)) u_dut (.core_clk(core_clk), .nrst(nrst),
        .host_sel(host_sel), .host_wr(host_wr), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_rdata(host_rdata), .in_config(in_config),
        .cycle_start(ev[0]), .cycle_end(ev[1]), .cycle_odd(cycle_odd),
        .cycle_count(cyc_cnt), .macrotick(mtick), .offset_meas_short(off_short),
        .rate_pair_short(rate_short), .sync_frame_seen(ev[2]), .corr_valid(ev[3]),
        .offset_corr_mag(off_mag), .rate_corr_mag(rate_mag), .guardian_err_a(ev[4]),
        .guardian_err_b(ev[5]), .slot_counter_inc(slot_inc), .error_level(err_lvl),
        .illegal_state(ev[6]), .coldstart_retry_fail(ev[7]),
        .startup_frames_short(ev[8]), .coldstart_normal_entry(ev[9]),
        .coldstart_noise_entry(ev[10]), .sync_capture_en(sync_cap_en),
        .diag_stop(diag_stop), .irq(irq));
    // ==========================================================
    // helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("compares %0d, errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic fire(input int i);
        ev[i] = 1'b1;
        @(posedge core_clk);
        #DLY;
        ev[i] = 1'b0;
        @(posedge core_clk);
        #DLY;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge core_clk);
        #DLY;
    endtask
    // zero write keeps, read shows exp, one write clears
    task automatic check_reg(input logic [9:0] a, input logic [15:0] exp);
        u_host.wr(a, 16'h0000);
        u_host.rd(a, rd_val);
        check(rd_val, exp);
        u_host.wr(a, exp);
        u_host.rd(a, rd_val);
        check(rd_val, 16'h0000);
    endtask
    initial begin
        cycles(20000);
        error_cnt++;
        $display("mismatch at %0t: run limit used up", $time);
        complete_run();
    end
    // ==========================================================
    // main sequence
    initial begin
        {nrst, in_config, cycle_odd, off_short, rate_short} = 5'b01000;
        {off_mag, rate_mag, cyc_cnt, mtick, slot_inc, err_lvl, ev} = '0;
        repeat (8) @(posedge core_clk);
        #DLY;
        nrst = 1'b1;
        cycles(1);
        u_host.rd(OFS_MAIN_STATUS, rd_val);
        check(rd_val, 16'h00c0);
        check({15'h0, irq}, 16'h0000);
        u_host.rd(OFS_STARTUP_STATUS, rd_val);
        check(rd_val, 16'h0000);
        mtick = 14'h0005;
        in_config = 1'b0;
        cycles(2);
        u_host.rd(OFS_MAIN_STATUS, rd_val);
        check(rd_val, 16'h0000);
        fire(0);
        check_reg(OFS_MAIN_STATUS, 16'h0020);
        fire(4);
        check_reg(OFS_MAIN_STATUS, 16'h0200);
        fire(5);
        check_reg(OFS_MAIN_STATUS, 16'h0200);
        {off_short, rate_short} = 2'b11;
        fire(1);
        check_reg(OFS_MAIN_STATUS, 16'h0100);
        {off_short, cycle_odd} = 2'b01;
        fire(1);
        check_reg(OFS_MAIN_STATUS, 16'h0800);
        u_host.wr(OFS_SLOT_MASK, 16'h0004);
        slot_inc = 8'h02;
        cycles(1);
        slot_inc = 8'h04;
        cycles(1);
        slot_inc = 8'h00;
        check_reg(OFS_MAIN_STATUS, 16'h0400);
        err_lvl = 2'h1;
        cycles(2);
        check_reg(OFS_MAIN_STATUS, 16'h1000);
        u_host.wr(OFS_SYNC_LIMIT, 16'h0002);
        check({15'h0, sync_cap_en}, 16'h0001);
        fire(2);
        fire(2);
        check({15'h0, sync_cap_en}, 16'h0000);
        check_reg(OFS_MAIN_STATUS, 16'h0000);
        fire(2);
        check_reg(OFS_MAIN_STATUS, 16'h2000);
        u_host.wr(OFS_OFFSET_LIMIT, 16'h0100);
        u_host.wr(OFS_RATE_LIMIT, 16'h0010);
        off_mag = 16'h00ff;
        fire(3);
        check_reg(OFS_MAIN_STATUS, 16'h0000);
        off_mag = 16'h0100;
        fire(3);
        check_reg(OFS_MAIN_STATUS, 16'h4000);
        {off_mag, rate_mag} = {16'h0000, 16'h0010};
        fire(3);
        check_reg(OFS_MAIN_STATUS, 16'h4000);
        u_host.wr(OFS_TIMER0_CYC, 16'h0003);
        u_host.wr(OFS_TIMER0_MT, 16'h0010);
        u_host.wr(OFS_TIMER1_CYC, 16'h0005);
        u_host.wr(OFS_TIMER1_MT, 16'h0020);
        {cyc_cnt, mtick} = {6'h03, 14'h0010};
        cycles(1);
        mtick = 14'h0011;
        check_reg(OFS_MAIN_STATUS, 16'h0040);
        {cyc_cnt, mtick} = {6'h05, 14'h0020};
        cycles(1);
        mtick = 14'h0021;
        check_reg(OFS_MAIN_STATUS, 16'h0080);
        u_host.wr(OFS_MAIN_EN, 16'h0020);
        fire(4);
        check({15'h0, irq}, 16'h0000);
        fire(0);
        cycles(3);
        check({15'h0, irq}, 16'h0001);
        fork
            u_host.wr(OFS_MAIN_STATUS, 16'h0220);
            fire(0);
        join
        check({15'h0, irq}, 16'h0001);
        check_reg(OFS_MAIN_STATUS, 16'h0020);
        check({15'h0, irq}, 16'h0000);
        // startup flags
        u_host.wr(OFS_RETRY_LIMIT, 16'h0002);
        fire(7);
        check_reg(OFS_STARTUP_STATUS, 16'h0000);
        fire(7);
        check_reg(OFS_STARTUP_STATUS, 16'h0001);
        fire(8);
        check_reg(OFS_STARTUP_STATUS, 16'h0002);
        u_host.wr(OFS_STARTUP_EN, 16'h0004);
        fire(9);
        check({15'h0, irq}, 16'h0001);
        check_reg(OFS_STARTUP_STATUS, 16'h0004);
        check({15'h0, irq}, 16'h0000);
        fork
            u_host.wr(OFS_STARTUP_STATUS, 16'hffff);
            fire(10);
        join
        check_reg(OFS_STARTUP_STATUS, 16'h0008);
        u_host.rd(10'h3fe, rd_val);
        check(rd_val, 16'h0000);
        // fatal and config exit
        fire(10);
        fire(0);
        fire(6);
        check({15'h0, diag_stop}, 16'h0001);
        u_host.rd(OFS_MAIN_STATUS, rd_val);
        check(rd_val, 16'h8020);
        in_config = 1'b1;
        cycles(2);
        check({15'h0, diag_stop}, 16'h0000);
        in_config = 1'b0;
        cycles(2);
        u_host.rd(OFS_MAIN_STATUS, rd_val);
        check(rd_val, 16'h0000);
        u_host.rd(OFS_STARTUP_STATUS, rd_val);
        check(rd_val, 16'h0000);
        complete_run();
    end
endmodule
